// ==== pkg/cis_consts.svh ====
/*
 * Constants of the converter I/O sequencer: clock rate, filter and hold
 * times, switch codes, register offsets, field positions, reset values.
 * Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
 */
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH
// ==========================================
// timing
`define CIS_CLK_MHZ 250
`define CIS_FILT_NS 1000
`define CIS_FILT_CYC ((`CIS_FILT_NS * `CIS_CLK_MHZ + 999) / 1000)
`define CIS_RES_HOLD_MS 100
`define CIS_RES_HOLD_CYC (`CIS_RES_HOLD_MS * `CIS_CLK_MHZ * 1000)
// ==========================================
// setting switch codes
`define CIS_SW_ESTOP_EN 4'h4
`define CIS_SW_MC_OFF 4'h1
// ==========================================
// register offsets
`define CIS_ADDR_STATUS 8'h00
`define CIS_ADDR_CLASS 8'h04
`define CIS_ADDR_INT_STAT 8'h08
`define CIS_ADDR_INT_CLR 8'h0C
`define CIS_ADDR_INT_EN 8'h10
// ==========================================
// fields and reset values
`define CIS_STAT_SW_LSB 4
`define CIS_STAT_ALM_LSB 8
`define CIS_STAT_RES_BIT 16
`define CIS_INT_ALARM 0
`define CIS_INT_ESTOP 1
`define CIS_INT_RESET 2
`define CIS_INT_DROP 3
`define CIS_CLASS_RST 8'hFF
`define CIS_INT_EN_RST 4'h0
`endif

// ==== pkg/cis_pkg.sv ====
/*
 * Types of the converter I/O sequencer: state codes and bus carriers.
 * Assumes the constants header is included by cis_io_sequencer and the bench.
 */
package cis_pkg;
	// ==========================================
	// types
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_READY = 4'h2,
		ST_ESTOP = 4'h4,
		ST_ALARM = 4'h8
	} cis_state_e;
	typedef logic [7:0] cis_fault_t;
	typedef logic [3:0] cis_irq_t;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} cis_ahb_req_s;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} cis_ahb_rsp_s;
endpackage

// ==== design/cis_sync_filter.sv ====
/*
 * Two-flop synchroniser followed by a stability filter for a pin group.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module cis_sync_filter #(
	parameter int W = 1,
	parameter int FILT = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	localparam int CW = $clog2(FILT + 1);
	logic [W-1:0] s1, s2, s3;
	logic [CW-1:0] cnt;
	wire logic hold = (s2 != s3) || (s2 == dout);
	wire logic done = (cnt == CW'(FILT - 1));
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			dout <= '0;
		end else if (hold) begin
			cnt <= '0;
		end else if (done) begin
			cnt <= '0;
			dout <= s2;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end
	a_filter_stable: assert property (@(posedge clk) disable iff (!reset_n)
		(dout != $past(dout)) |-> ($past(s2, 2) == dout && $past(cnt) == CW'(FILT - 1)))
		else $error("filtered output changed without a stable input");
endmodule // cis_sync_filter
`default_nettype wire

// ==== design/cis_hold_timer.sv ====
/*
 * Minimum-hold detector: one pulse once the level has stood HOLD cycles.
 * Assumes a synchronous, filtered input level.
 */
`timescale 1ns/100ps
`default_nettype none
module cis_hold_timer #(
	parameter int HOLD = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic lvl,
	output logic fire
);
	localparam int CW = $clog2(HOLD + 1);
	logic [CW-1:0] cnt;
	wire logic full = (cnt == CW'(HOLD));
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			fire <= 1'b0;
		end else begin
			cnt <= !lvl ? '0 : (full ? cnt : cnt + CW'(1));
			fire <= lvl && (cnt == CW'(HOLD - 1));
		end
	end
endmodule // cis_hold_timer
`default_nettype wire

// ==== design/cis_io_sequencer.sv ====
/*
 * Converter I/O sequencer: forced stop, alarm reset, alarm latch, ready
 * and permission outputs, alarm contact, contactor drive, register slave.
 * Assumes pins arrive asynchronously and a single AHB-Lite master.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cis_consts.svh"
module cis_io_sequencer import cis_pkg::*; #(
	parameter int RES_HOLD_CYC = `CIS_RES_HOLD_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic forcedStopIn,
	input wire logic alarmResetIn,
	input wire logic [3:0] converterSettingSwitch,
	input wire logic driveStartCmd,
	input wire cis_fault_t protectFault,
	input wire cis_ahb_req_s ahbReq,
	output cis_ahb_rsp_s ahbRsp,
	output logic alarmOut,
	output logic converterReadyOut,
	output logic operationPermitOut,
	output logic resetEchoOut,
	output logic alarmContactNo,
	output logic alarmContactNc,
	output logic contactorDriveA,
	output logic contactorDriveB,
	output logic mainCircuitOffWarning,
	output logic servoOffReq,
	output logic irq
);
	// ==========================================
	// pin conditioning
	logic [14:0] pinLvl;
	logic resetFire;
	cis_sync_filter #(
		.W(15),
		.FILT(`CIS_FILT_CYC)
	) u_pins (
		.clk(clk),
		.reset_n(reset_n),
		.din({protectFault, driveStartCmd, converterSettingSwitch, alarmResetIn, forcedStopIn}),
		.dout(pinLvl)
	);
	wire logic stopLvl = pinLvl[0];
	wire logic resLvl = pinLvl[1];
	wire logic [3:0] swLvl = pinLvl[5:2];
	wire logic startLvl = pinLvl[6];
	wire cis_fault_t faultLvl = pinLvl[14:7];
	cis_hold_timer #(
		.HOLD(RES_HOLD_CYC)
	) u_hold (
		.clk(clk),
		.reset_n(reset_n),
		.lvl(resLvl),
		.fire(resetFire)
	);

	// ==========================================
	// alarm latch
	cis_state_e state, nextState;
	cis_fault_t alarmLatch, classMask;
	wire logic estopEn = (swLvl == `CIS_SW_ESTOP_EN);
	wire logic mcEn = (swLvl != `CIS_SW_MC_OFF);
	wire logic estopActive = estopEn && !stopLvl;
	wire cis_fault_t faultSet = faultLvl & {8{startLvl}};
	wire cis_fault_t clrMask = resetFire ? classMask : 8'h00;
	wire cis_fault_t next_alarmLatch = (alarmLatch & ~clrMask) | faultSet;
	wire logic alarmActive = (alarmLatch != 8'h00);
	wire logic next_alarmActive = (next_alarmLatch != 8'h00);

	// ==========================================
	// sequence
	always_comb begin
		nextState = state;
		unique case (state)
			ST_OFF: begin
				if (alarmActive)
					nextState = ST_ALARM;
				else if (estopActive)
					nextState = ST_ESTOP;
				// ready-off holds while the alarm reset is still applied
				else if (startLvl && !resLvl)
					nextState = ST_READY;
			end
			ST_READY: begin
				if (alarmActive)
					nextState = ST_ALARM;
				else if (estopActive)
					nextState = ST_ESTOP;
				else if (resetFire || !startLvl)
					nextState = ST_OFF;
			end
			ST_ESTOP: begin
				if (!estopActive)
					nextState = alarmActive ? ST_ALARM : ST_OFF;
			end
			ST_ALARM: begin
				if (!alarmActive)
					nextState = ST_OFF;
			end
			default: nextState = ST_OFF;
		endcase
	end
	wire logic next_ready = (nextState == ST_READY);
	wire logic next_contactor = next_ready && mcEn;
	wire logic next_estop = (nextState == ST_ESTOP);

	// ==========================================
	// interrupt events
	cis_irq_t intStat, intEn, intClr;
	cis_irq_t events;
	assign events[`CIS_INT_ALARM] = |(faultSet & ~alarmLatch);
	assign events[`CIS_INT_ESTOP] = next_estop && (state != ST_ESTOP);
	assign events[`CIS_INT_RESET] = resetFire;
	assign events[`CIS_INT_DROP] = (state == ST_READY) && !next_ready;
	// an event wins over a clear in the same cycle
	wire cis_irq_t next_intStat = (intStat & ~intClr) | events;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_OFF;
			alarmLatch <= 8'h00;
			intStat <= 4'h0;
			irq <= 1'b0;
		end else begin
			state <= nextState;
			alarmLatch <= next_alarmLatch;
			intStat <= next_intStat;
			irq <= |(next_intStat & intEn);
		end
	end

	// ==========================================
	// pin outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alarmOut <= 1'b1;
			converterReadyOut <= 1'b0;
			operationPermitOut <= 1'b1;
			resetEchoOut <= 1'b0;
			alarmContactNo <= 1'b0;
			alarmContactNc <= 1'b1;
			contactorDriveA <= 1'b0;
			contactorDriveB <= 1'b0;
			mainCircuitOffWarning <= 1'b0;
			servoOffReq <= 1'b0;
		end else begin
			alarmOut <= !next_alarmActive;
			converterReadyOut <= next_ready;
			operationPermitOut <= !next_ready;
			resetEchoOut <= resLvl;
			alarmContactNo <= next_alarmActive;
			alarmContactNc <= !next_alarmActive;
			contactorDriveA <= next_contactor;
			contactorDriveB <= next_contactor;
			mainCircuitOffWarning <= next_estop;
			servoOffReq <= next_estop || (nextState == ST_ALARM);
		end
	end

	// ==========================================
	// register slave
	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction
	logic wrPend;
	logic [31:0] wrAddr;
	wire logic addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
	wire logic rdTake = addrPhase && !ahbReq.hwrite;
	wire logic wrClass = wrPend && hit(wrAddr, `CIS_ADDR_CLASS);
	wire logic wrIntEn = wrPend && hit(wrAddr, `CIS_ADDR_INT_EN);
	wire logic wrIntClr = wrPend && hit(wrAddr, `CIS_ADDR_INT_CLR);
	assign intClr = wrIntClr ? ahbReq.hwdata[3:0] : 4'h0;
	logic [31:0] statusWord, rdMux;
	assign statusWord = {15'h0000, resLvl, alarmLatch, swLvl, state};
	assign rdMux = hit(ahbReq.haddr, `CIS_ADDR_STATUS) ? statusWord :
		hit(ahbReq.haddr, `CIS_ADDR_CLASS) ? {24'h000000, classMask} :
		hit(ahbReq.haddr, `CIS_ADDR_INT_STAT) ? {28'h0000000, intStat} :
		hit(ahbReq.haddr, `CIS_ADDR_INT_EN) ? {28'h0000000, intEn} : 32'h00000000;

	// a write lands at the end of its data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend <= 1'b0;
			wrAddr <= 32'h00000000;
		end else if (ahbReq.hready) begin
			wrPend <= addrPhase && ahbReq.hwrite;
			wrAddr <= ahbReq.haddr;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			classMask <= `CIS_CLASS_RST;
			intEn <= `CIS_INT_EN_RST;
		end else begin
			if (wrClass)
				classMask <= ahbReq.hwdata[7:0];
			if (wrIntEn)
				intEn <= ahbReq.hwdata[3:0];
		end
	end
	// read data captured at the address phase, held until the next read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ahbRsp <= '{hrdata: 32'h00000000, hreadyout: 1'b0, hresp: 1'b0};
		end else begin
			ahbRsp.hreadyout <= 1'b1;
			ahbRsp.hresp <= 1'b0;
			if (rdTake)
				ahbRsp.hrdata <= rdMux;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_estop_hit;
		estopActive && (state inside {ST_OFF, ST_READY}) && !alarmActive;
	endsequence
	sequence s_estop_held;
		mainCircuitOffWarning && servoOffReq && !contactorDriveA && !contactorDriveB;
	endsequence
	a_estop_ignored: assert property ((!estopEn && state != ST_ESTOP) |=> state != ST_ESTOP)
		else $error("forced stop entered while disabled");
	a_estop_entry: assert property (s_estop_hit |=> s_estop_held)
		else $error("forced stop did not drop contactor and servo");
	a_estop_exit: assert property ((state == ST_ESTOP && !estopActive && !alarmActive) |=> state == ST_OFF)
		else $error("forced stop not left on input return");
	a_class_keep: assert property (resetFire |=> ((($past(alarmLatch) & ~$past(classMask)) & ~alarmLatch) == 8'h00))
		else $error("non-resettable alarm cleared");
	a_reset_idle: assert property ((state == ST_READY && resetFire && !alarmActive && !estopActive)
		|=> state == ST_OFF ##1 !converterReadyOut)
		else $error("reset without alarm did not reach ready-off");
	a_alarm_pin: assert property (alarmOut == (alarmLatch == 8'h00))
		else $error("alarm output does not follow alarm latch");
	a_ready_perm: assert property (converterReadyOut == (state == ST_READY) && operationPermitOut == !converterReadyOut)
		else $error("ready or permission output wrong");
	a_reset_echo: assert property ($rose(resLvl) |=> resetEchoOut)
		else $error("reset echo missing");
	a_contact_legs: assert property (alarmContactNo == alarmActive && alarmContactNc == !alarmContactNo)
		else $error("alarm contact legs wrong");
	a_contactor_close: assert property ((nextState == ST_READY && mcEn) |=> contactorDriveA && contactorDriveB)
		else $error("contactor not closed in ready");
	a_contactor_off: assert property ((!mcEn && state != ST_READY) |=> !contactorDriveA)
		else $error("contactor driven while disabled");
	a_contactor_open: assert property ((state == ST_READY && !startLvl) |=> (!contactorDriveA && !contactorDriveB))
		else $error("contactor not opened at ready-off");
	a_servo_gate: assert property ((!startLvl && alarmLatch == 8'h00) |=> alarmLatch == 8'h00)
		else $error("alarm latched during servo-off");
	a_estop_outputs: assert property (state == ST_ESTOP |-> !contactorDriveA && !contactorDriveB && servoOffReq)
		else $error("forced stop outputs wrong");
	a_reset_hold: assert property ((state == ST_OFF && resLvl) |=> state != ST_READY)
		else $error("left ready-off while alarm reset applied");
endmodule // cis_io_sequencer
`default_nettype wire

// ==== bench/cis_far_model.sv ====
/*
 * Far-side model: drive unit start command, external sequence pins, trips.
 * Assumes the bench calls its tasks; pins change just after a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module cis_far_model (
	input wire logic clk,
	output var logic driveStartCmd,
	output var logic forcedStopIn,
	output var logic alarmResetIn,
	output var logic [3:0] converterSettingSwitch,
	output var logic [7:0] protectFault
);
	initial begin
		driveStartCmd = 1'b1;
		forcedStopIn = 1'b1;
		alarmResetIn = 1'b0;
		converterSettingSwitch = 4'h4;
		protectFault = 8'h00;
	end
	// ==========================================
	// pin levels
	task automatic pins(input logic st, input logic fs, input logic [3:0] sw, input logic [7:0] flt);
		@(posedge clk);
		driveStartCmd <= st;
		forcedStopIn <= fs;
		converterSettingSwitch <= sw;
		protectFault <= flt;
	endtask
	// callers hold the level far beyond the hold time, for alarm handling and for a reset out of ready
	task automatic resLevel(input logic v);
		@(posedge clk);
		alarmResetIn <= v;
	endtask
endmodule // cis_far_model
`default_nettype wire

// ==== bench/converter_io_sequencer_tb_top.sv ====
/*
 * Testbench of the converter I/O sequencer: bus tasks, pin scenarios.
 * Assumes the design package, constants header and far-side model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cis_consts.svh"
module converter_io_sequencer_tb_top import cis_pkg::*;;
	logic clk, reset_n, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic driveStartCmd, forcedStopIn, alarmResetIn;
	logic [3:0] converterSettingSwitch;
	logic [7:0] protectFault;
	cis_ahb_req_s ahbReq;
	cis_ahb_rsp_s ahbRsp;
	logic alarmOut, converterReadyOut, operationPermitOut, resetEchoOut, alarmContactNo, alarmContactNc;
	logic contactorDriveA, contactorDriveB, mainCircuitOffWarning, servoOffReq, irq;
	int fails, compares;
	assign ahbReq = {hsel, haddr, htrans, hwrite, hsize, hwdata, ahbRsp.hreadyout};
	wire logic [9:0] outs = {alarmOut, converterReadyOut, operationPermitOut, resetEchoOut,
		alarmContactNo, alarmContactNc, contactorDriveA, contactorDriveB, mainCircuitOffWarning, servoOffReq};
	cis_far_model far (.clk(clk), .driveStartCmd(driveStartCmd), .forcedStopIn(forcedStopIn),
		.alarmResetIn(alarmResetIn), .converterSettingSwitch(converterSettingSwitch), .protectFault(protectFault));
	cis_io_sequencer #(.RES_HOLD_CYC(8)) DUT (.clk(clk), .reset_n(reset_n), .forcedStopIn(forcedStopIn),
		.alarmResetIn(alarmResetIn), .converterSettingSwitch(converterSettingSwitch),
		.driveStartCmd(driveStartCmd), .protectFault(protectFault), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
		.alarmOut(alarmOut), .converterReadyOut(converterReadyOut), .operationPermitOut(operationPermitOut),
		.resetEchoOut(resetEchoOut), .alarmContactNo(alarmContactNo), .alarmContactNc(alarmContactNc),
		.contactorDriveA(contactorDriveA), .contactorDriveB(contactorDriveB),
		.mainCircuitOffWarning(mainCircuitOffWarning), .servoOffReq(servoOffReq), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic waitRdy();
		do begin
			@(posedge clk);
		end while (ahbRsp.hreadyout !== 1'b1);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy();
		rd = ahbRsp.hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h00000000, x);
		chk(x & mask, exp);
	endtask
	// pin changes pass sync and a fixed 250-cycle filter
	task automatic settle();
		repeat (300) @(posedge clk);
	endtask
	task automatic chkOut(input logic [9:0] exp);
		chk({22'h000000, outs}, {22'h000000, exp});
	endtask
	task automatic resPulse();
		far.resLevel(1'b1);
		settle();
		far.resLevel(1'b0);
		settle();
	endtask
	// ==========================================
	// watchdog
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	// ==========================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chkOut(10'h290);
		rdc(`CIS_ADDR_CLASS, 32'h000000FF, 32'h000000FF);
		rdc(`CIS_ADDR_INT_EN, 32'h0000000F, 32'h00000000);
		wr(8'h24, 32'hFFFFFFFF);
		rdc(8'h24, 32'hFFFFFFFF, 32'h00000000);
		settle();
		chkOut(10'h31C);
		rdc(`CIS_ADDR_STATUS, 32'h0000FFFF, 32'h00000042);
		wr(`CIS_ADDR_INT_CLR, 32'h0000000F);
		wr(`CIS_ADDR_INT_EN, 32'h00000002);
		chk({31'h0, irq}, 32'h00000000);
		far.pins(1'b1, 1'b0, 4'h4, 8'h00);
		settle();
		chkOut(10'h293);
		rdc(`CIS_ADDR_STATUS, 32'h0000FFFF, 32'h00000044);
		chk({31'h0, irq}, 32'h00000001);
		wr(`CIS_ADDR_INT_CLR, 32'h00000002);
		rdc(`CIS_ADDR_INT_STAT, 32'h0000000F, 32'h00000008);
		chk({31'h0, irq}, 32'h00000000);
		far.pins(1'b1, 1'b1, 4'h4, 8'h00);
		settle();
		chkOut(10'h31C);
		far.pins(1'b1, 1'b1, 4'h0, 8'h00);
		settle();
		far.pins(1'b1, 1'b0, 4'h0, 8'h00);
		settle();
		chkOut(10'h31C);
		far.pins(1'b1, 1'b1, 4'h1, 8'h00);
		settle();
		chkOut(10'h310);
		far.pins(1'b0, 1'b1, 4'h4, 8'h00);
		settle();
		chkOut(10'h290);
		far.pins(1'b0, 1'b1, 4'h4, 8'h03);
		settle();
		chkOut(10'h290);
		far.pins(1'b0, 1'b1, 4'h4, 8'h00);
		settle();
		far.pins(1'b1, 1'b1, 4'h4, 8'h00);
		settle();
		wr(`CIS_ADDR_CLASS, 32'h00000001);
		rdc(`CIS_ADDR_CLASS, 32'h000000FF, 32'h00000001);
		far.pins(1'b1, 1'b1, 4'h4, 8'h03);
		settle();
		chkOut(10'h0A1);
		rdc(`CIS_ADDR_STATUS, 32'h0000FFFF, 32'h00000348);
		far.pins(1'b1, 1'b1, 4'h4, 8'h00);
		settle();
		far.resLevel(1'b1);
		settle();
		chkOut(10'h0E1);
		far.resLevel(1'b0);
		settle();
		chkOut(10'h0A1);
		rdc(`CIS_ADDR_STATUS, 32'h0000FFFF, 32'h00000248);
		wr(`CIS_ADDR_CLASS, 32'h000000FF);
		resPulse();
		settle();
		chkOut(10'h31C);
		wr(`CIS_ADDR_INT_CLR, 32'h0000000F);
		resPulse();
		rdc(`CIS_ADDR_INT_STAT, 32'h00000008, 32'h00000008);
		end_of_test();
	end
endmodule // converter_io_sequencer_tb_top
`default_nettype wire
